//--- core/sgfl_consts.svh
/*
  Register map, field positions, reset values and timing counts for the
  switch global frame and lookup configuration bank.
  Assumes inclusion by its bare name from design files.
*/
`ifndef SGFL_CONSTS_SVH
`define SGFL_CONSTS_SVH

// Printed offsets are register indices (not all multiples of four)
`define SGFL_IDX_STA3 16'h0305
`define SGFL_IDX_STA4 16'h0306
`define SGFL_IDX_STA5 16'h0307
`define SGFL_IDX_MAXLEN 16'h0308
`define SGFL_IDX_PTAG 16'h030A
`define SGFL_IDX_RTAG 16'h030C
`define SGFL_IDX_SHAPER 16'h030E
`define SGFL_IDX_LKP0 16'h0310
// Upper station address bytes, chosen offset for this slice
`define SGFL_IDX_STAHI 16'h0302
// Status register of the bank, chosen offset
`define SGFL_IDX_STATUS 16'h0320

// Reset values
`define SGFL_RST_STA 8'hFF
`define SGFL_RST_STAHI 24'h00_10A1
`define SGFL_RST_MAXLEN 16'h07D0
`define SGFL_RST_PTAG 16'h9100
`define SGFL_RST_RTAG 16'h892F
`define SGFL_RST_SHAPER 2'b11
`define SGFL_RST_LKP0 8'h61

// Field positions and limits
`define SGFL_MAXLEN_MSB 13
`define SGFL_MAXLEN_JUMBO 14'h2328
`define SGFL_LKP_VLAN 7
`define SGFL_LKP_DROPVID 6
`define SGFL_LKP_AGE_MSB 5
`define SGFL_LKP_AGE_LSB 3
`define SGFL_LKP_RSVMC 2
`define SGFL_SHP_SHAPE 1
`define SGFL_SHP_POLICE 0
`define SGFL_HASH_CRC 2'b01
`define SGFL_HASH_XOR 2'b10

// Timing: register updates land one cycle after the write is taken
`define SGFL_CLK_NS 5
`define SGFL_PREAMBLE_IPG 8'h14

`endif

//--- core/sgfl_pkg.sv
/*
  Types shared by the configuration bank files.
  Assumes the constants header is available on the include path.
*/
package sgfl_pkg;
  typedef enum logic [1:0] {
    SGFL_HASH_DIRECT0,
    SGFL_HASH_CRC,
    SGFL_HASH_XOR,
    SGFL_HASH_DIRECT3
  } sgfl_hash_t;

  typedef struct packed {
    logic [47:0] stationAddr;
    logic [13:0] maxFrameLen;
    logic [15:0] providerTag;
    logic [15:0] ringTag;
    logic shapeFull;
    logic policeFull;
    logic vlanEnable;
    logic dropInvalidVid;
    logic [2:0] ageCount;
    logic rsvMcLookup;
    logic [1:0] tableHashSelect;
  } sgfl_cfg_t;
endpackage

//--- core/sgfl_cfg_if.sv
/*
  Carries the decoded configuration from the register bank to the lookup
  helper. Assumes one clock domain.
*/
`timescale 1ns/100ps
interface sgfl_cfg_if;
  import sgfl_pkg::*;
  sgfl_cfg_t cfg;
  modport bank (output cfg);
  modport user (input cfg);
endinterface // sgfl_cfg_if

//--- core/sgfl_lookup_index.sv
/*
  Table index calculation, frame length clamp and tag choice for one frame.
  Assumes the configuration is stable while a frame is processed.
*/
`timescale 1ns/100ps
`include "sgfl_consts.svh"
module sgfl_lookup_index
  import sgfl_pkg::*;
(
  sgfl_cfg_if.user cfgBus,
  input wire logic [47:0] destAddr,
  input wire logic [13:0] frameLen,
  input wire logic frameTagged,
  input wire logic [47:0] srcAddr,
  output logic [9:0] tableIndex,
  output logic [13:0] keptLen,
  output logic [15:0] defaultTag,
  output logic selfAddressed
);
  logic [9:0] crcIdx;
  logic [9:0] xorIdx;

  ////////////////////////////////////////////////////////////////////////
  // Hash folds: CRC-style feedback over the address, or plain XOR folding
  always_comb begin
    logic [9:0] c;
    c = 10'h3FF;
    for (int i = 0; i < 48; i++) begin
      c = {c[8:0], 1'b0} ^ ((c[9] ^ destAddr[i]) ? 10'h233 : 10'h000);
    end
    crcIdx = c;
    xorIdx = destAddr[9:0] ^ destAddr[19:10] ^ destAddr[29:20] ^ destAddr[39:30]
      ^ {2'b00, destAddr[47:40]};
  end

  // Index select, direct mapping for both 00 and 11
  always_comb begin
    unique case (sgfl_hash_t'(cfgBus.cfg.tableHashSelect))
      SGFL_HASH_CRC: tableIndex = crcIdx;
      SGFL_HASH_XOR: tableIndex = xorIdx;
      SGFL_HASH_DIRECT0,
      SGFL_HASH_DIRECT3: tableIndex = destAddr[9:0];
    endcase
  end

  // Oversized payloads are cut to the programmed maximum
  assign keptLen = (frameLen > cfgBus.cfg.maxFrameLen) ? cfgBus.cfg.maxFrameLen : frameLen;
  // Untagged frames take the provider tag type as default
  assign defaultTag = frameTagged ? cfgBus.cfg.ringTag : cfgBus.cfg.providerTag;
  assign selfAddressed = (srcAddr == cfgBus.cfg.stationAddr);
endmodule // sgfl_lookup_index

//--- core/sgfl_credit_calc.sv
/*
  Credit cost of one frame for the shaper and the policer.
  Assumes byte counts, with gap and preamble added as a fixed overhead.
*/
`timescale 1ns/100ps
`include "sgfl_consts.svh"
module sgfl_credit_calc
  import sgfl_pkg::*;
(
  sgfl_cfg_if.user cfgBus,
  input wire logic [13:0] dataBytes,
  output logic [14:0] shapeCost,
  output logic [14:0] policeCost
);
  ////////////////////////////////////////////////////////////////////////
  // Overhead is charged only when the full-accounting bit is set
  assign shapeCost = {1'b0, dataBytes}
    + (cfgBus.cfg.shapeFull ? {7'h00, `SGFL_PREAMBLE_IPG} : 15'h0000);
  assign policeCost = {1'b0, dataBytes}
    + (cfgBus.cfg.policeFull ? {7'h00, `SGFL_PREAMBLE_IPG} : 15'h0000);
endmodule // sgfl_credit_calc

//--- core/sgfl_bank.sv
/*
  Global frame and lookup configuration bank with AXI4-Lite slave.
  Assumes a single clock, asynchronous active-high reset, and a master that
  keeps at most one write and one read outstanding.
*/
// Implementation choice: register access over AXI4-Lite.
// Behaviour
// - Max frame length is bits 13:0, resets to 2000; longer payloads are truncated.
// - Max frame length accepts values up to 9000 for jumbo frames.
// - Provider tag type resets 0x9100; default for untagged and outer tag (tagged frames here get the ring tag type).
// - Ring tag type resets 0x892F and identifies ring-redundancy frames.
// - Shaper bit 1: 1 charges data plus gap and preamble, 0 data only.
// - Policer bit 0: 1 charges data plus gap and preamble, 0 data only.
// - Lookup bit 7 enables VLAN mode, resets to 0.
// - Lookup bit 6 resets 1: drop invalid VID, else forward to host.
// - Unknown-VLAN forwarding, when enabled, overrides the invalid VID drop.
// - Age count bits 5:3 reset to 100 and load into updated entries.
// - Aging time comes from age count together with the age period.
// - Lookup bit 2 enables the reserved multicast table, resets to 0.
// - Hash select 00 or 11 indexes directly by ten low address bits.
// - Hash select resets to 01; 01 is CRC hash, 10 is XOR hash.
// - Six station bytes form the own address for pause and self-filtering.
`timescale 1ns/100ps
`include "sgfl_consts.svh"
module sgfl_bank
  import sgfl_pkg::*;
(
  input wire logic clk,
  input wire logic rst,
  input wire logic [17:0] s_axi_awaddr,
  input wire logic s_axi_awvalid,
  output logic s_axi_awready,
  input wire logic [31:0] s_axi_wdata,
  input wire logic [3:0] s_axi_wstrb,
  input wire logic s_axi_wvalid,
  output logic s_axi_wready,
  output logic [1:0] s_axi_bresp,
  output logic s_axi_bvalid,
  input wire logic s_axi_bready,
  input wire logic [17:0] s_axi_araddr,
  input wire logic s_axi_arvalid,
  output logic s_axi_arready,
  output logic [31:0] s_axi_rdata,
  output logic [1:0] s_axi_rresp,
  output logic s_axi_rvalid,
  input wire logic s_axi_rready,
  input wire logic [47:0] destAddr,
  input wire logic [47:0] srcAddr,
  input wire logic [13:0] frameLen,
  input wire logic frameTagged,
  input wire logic frameValid,
  input wire logic invalidVid,
  input wire logic unknownVidFwd,
  input wire logic entryUpdate,
  input wire logic [7:0] agePeriod,
  output logic [9:0] tableIndex,
  output logic [13:0] keptLen,
  output logic [15:0] frameTagType,
  output logic [14:0] shapeCost,
  output logic [14:0] policeCost,
  output logic frameDrop,
  output logic toHostPort,
  output logic selfDrop,
  output logic [2:0] entryAgeCount,
  output logic [10:0] agingTime,
  output logic vlanMode,
  output logic rsvMcEnable
);
  typedef struct packed {
    sgfl_cfg_t cfg;
    logic [15:0] maxLenRaw;
    logic [17:0] awAddr;
    logic awHeld;
    logic [31:0] wData;
    logic [3:0] wStrb;
    logic wHeld;
    logic bValid;
    logic [1:0] bResp;
    logic rValid;
    logic [31:0] rData;
    logic [1:0] rResp;
    logic awRdy;
    logic wRdy;
    logic arRdy;
    logic [9:0] tableIndex;
    logic [13:0] keptLen;
    logic [15:0] frameTagType;
    logic [14:0] shapeCost;
    logic [14:0] policeCost;
    logic frameDrop;
    logic toHostPort;
    logic selfDrop;
    logic [2:0] entryAgeCount;
    logic [10:0] agingTime;
    logic [9:0] framesSeen;
  } sgfl_state_t;

  sgfl_state_t state_r;
  sgfl_state_t state_nxt;
  sgfl_cfg_if cfgBus();
  logic [9:0] idxComb;
  logic [13:0] lenComb;
  logic [15:0] tagComb;
  logic selfComb;
  logic [14:0] shapeComb;
  logic [14:0] policeComb;

  assign cfgBus.cfg = state_r.cfg;

  ////////////////////////////////////////////////////////////////////////
  // Datapath helpers
  sgfl_lookup_index lookupIdx (
    .cfgBus(cfgBus.user),
    .destAddr(destAddr),
    .frameLen(frameLen),
    .frameTagged(frameTagged),
    .srcAddr(srcAddr),
    .tableIndex(idxComb),
    .keptLen(lenComb),
    .defaultTag(tagComb),
    .selfAddressed(selfComb)
  );

  sgfl_credit_calc creditCalc (
    .cfgBus(cfgBus.user),
    .dataBytes(lenComb),
    .shapeCost(shapeComb),
    .policeCost(policeComb)
  );

  ////////////////////////////////////////////////////////////////////////
  // Register read mux, index is byte address divided by four
  function automatic logic [32:0] readReg(input sgfl_state_t s, input logic [15:0] idx);
    logic [32:0] v;
    v = {1'b0, 32'h0000_0000};
    unique case (idx)
      `SGFL_IDX_STA3: v[7:0] = s.cfg.stationAddr[23:16];
      `SGFL_IDX_STA4: v[7:0] = s.cfg.stationAddr[15:8];
      `SGFL_IDX_STA5: v[7:0] = s.cfg.stationAddr[7:0];
      `SGFL_IDX_STAHI: v[23:0] = s.cfg.stationAddr[47:24];
      `SGFL_IDX_MAXLEN: v[15:0] = s.maxLenRaw;
      `SGFL_IDX_PTAG: v[15:0] = s.cfg.providerTag;
      `SGFL_IDX_RTAG: v[15:0] = s.cfg.ringTag;
      `SGFL_IDX_SHAPER: v[1:0] = {s.cfg.shapeFull, s.cfg.policeFull};
      `SGFL_IDX_LKP0: v[7:0] = {s.cfg.vlanEnable, s.cfg.dropInvalidVid, s.cfg.ageCount,
        s.cfg.rsvMcLookup, s.cfg.tableHashSelect};
      `SGFL_IDX_STATUS: v[9:0] = s.framesSeen;
      default: v[32] = 1'b1;
    endcase
    return v;
  endfunction

  ////////////////////////////////////////////////////////////////////////
  // Next-state logic: bus slave, register writes and frame decisions
  always_comb begin
    logic [15:0] wIdx;
    logic [31:0] wd;
    logic [32:0] rd;
    logic doWrite;
    wIdx = 16'h0000;
    wd = 32'h0000_0000;
    rd = 33'h0_0000_0000;
    doWrite = 1'b0;
    state_nxt = state_r;

    // Address and data are latched independently, in either order
    if (s_axi_awvalid && !state_r.awHeld) begin
      state_nxt.awAddr = s_axi_awaddr;
      state_nxt.awHeld = 1'b1;
    end
    if (s_axi_wvalid && !state_r.wHeld) begin
      state_nxt.wData = s_axi_wdata;
      state_nxt.wStrb = s_axi_wstrb;
      state_nxt.wHeld = 1'b1;
    end
    if (s_axi_bvalid && s_axi_bready) begin
      state_nxt.bValid = 1'b0;
    end

    // Commit once both halves are in and no response is pending
    if (state_r.awHeld && state_r.wHeld && !state_r.bValid) begin
      doWrite = 1'b1;
      wIdx = state_r.awAddr[17:2];
      wd = state_r.wData;
      state_nxt.awHeld = 1'b0;
      state_nxt.wHeld = 1'b0;
      state_nxt.bValid = 1'b1;
      state_nxt.bResp = (readReg(state_r, wIdx) >> 32 != 33'h0) ? 2'b10 : 2'b00;
    end

    // Byte lanes gate each field; narrow registers use the low lanes only
    if (doWrite) begin
      unique case (wIdx)
        `SGFL_IDX_STA3: if (state_r.wStrb[0]) state_nxt.cfg.stationAddr[23:16] = wd[7:0];
        `SGFL_IDX_STA4: if (state_r.wStrb[0]) state_nxt.cfg.stationAddr[15:8] = wd[7:0];
        `SGFL_IDX_STA5: if (state_r.wStrb[0]) state_nxt.cfg.stationAddr[7:0] = wd[7:0];
        `SGFL_IDX_STAHI: begin
          for (int b = 0; b < 3; b++) begin
            if (state_r.wStrb[b]) state_nxt.cfg.stationAddr[24 + 8*b +: 8] = wd[8*b +: 8];
          end
        end
        `SGFL_IDX_MAXLEN: begin
          for (int b = 0; b < 2; b++) begin
            if (state_r.wStrb[b]) state_nxt.maxLenRaw[8*b +: 8] = wd[8*b +: 8];
          end
        end
        `SGFL_IDX_PTAG: begin
          for (int b = 0; b < 2; b++) begin
            if (state_r.wStrb[b]) state_nxt.cfg.providerTag[8*b +: 8] = wd[8*b +: 8];
          end
        end
        `SGFL_IDX_RTAG: begin
          for (int b = 0; b < 2; b++) begin
            if (state_r.wStrb[b]) state_nxt.cfg.ringTag[8*b +: 8] = wd[8*b +: 8];
          end
        end
        `SGFL_IDX_SHAPER: begin
          if (state_r.wStrb[0]) begin
            state_nxt.cfg.shapeFull = wd[`SGFL_SHP_SHAPE];
            state_nxt.cfg.policeFull = wd[`SGFL_SHP_POLICE];
          end
        end
        `SGFL_IDX_LKP0: begin
          if (state_r.wStrb[0]) begin
            state_nxt.cfg.vlanEnable = wd[`SGFL_LKP_VLAN];
            state_nxt.cfg.dropInvalidVid = wd[`SGFL_LKP_DROPVID];
            state_nxt.cfg.ageCount = wd[`SGFL_LKP_AGE_MSB:`SGFL_LKP_AGE_LSB];
            state_nxt.cfg.rsvMcLookup = wd[`SGFL_LKP_RSVMC];
            state_nxt.cfg.tableHashSelect = wd[1:0];
          end
        end
        default: ;
      endcase
    end
    // The length field tracks the low bits of the raw word
    state_nxt.cfg.maxFrameLen = state_nxt.maxLenRaw[`SGFL_MAXLEN_MSB:0];

    // Read channel: one read answered at a time
    if (s_axi_rvalid && s_axi_rready) begin
      state_nxt.rValid = 1'b0;
    end
    if (s_axi_arvalid && !state_r.rValid) begin
      rd = readReg(state_r, s_axi_araddr[17:2]);
      state_nxt.rData = rd[31:0];
      state_nxt.rResp = rd[32] ? 2'b10 : 2'b00;
      state_nxt.rValid = 1'b1;
    end

    // Per-frame decisions, registered so outputs come from flip-flops
    if (frameValid) begin
      state_nxt.tableIndex = idxComb;
      state_nxt.keptLen = lenComb;
      state_nxt.frameTagType = tagComb;
      state_nxt.shapeCost = shapeComb;
      state_nxt.policeCost = policeComb;
      // Unknown-VLAN forwarding wins over the drop bit
      state_nxt.frameDrop = state_r.cfg.vlanEnable && invalidVid && !unknownVidFwd
        && state_r.cfg.dropInvalidVid;
      state_nxt.toHostPort = state_r.cfg.vlanEnable && invalidVid && !unknownVidFwd
        && !state_r.cfg.dropInvalidVid;
      state_nxt.selfDrop = selfComb;
      state_nxt.framesSeen = state_r.framesSeen + 10'h001;
    end
    if (entryUpdate) begin
      state_nxt.entryAgeCount = state_r.cfg.ageCount;
    end
    // Aging time is age count times age period
    state_nxt.agingTime = 11'(state_r.cfg.ageCount) * 11'(agePeriod);
    // Readies are flops of their own so that no gate sits behind the ports
    state_nxt.awRdy = !state_nxt.awHeld;
    state_nxt.wRdy = !state_nxt.wHeld;
    state_nxt.arRdy = !state_nxt.rValid;
  end

  ////////////////////////////////////////////////////////////////////////
  // State register
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      state_r <= '0;
      state_r.awRdy <= 1'b1;
      state_r.wRdy <= 1'b1;
      state_r.arRdy <= 1'b1;
      state_r.cfg.stationAddr <= {`SGFL_RST_STAHI, {3{`SGFL_RST_STA}}};
      state_r.maxLenRaw <= `SGFL_RST_MAXLEN;
      state_r.cfg.maxFrameLen <= 14'(`SGFL_RST_MAXLEN);
      state_r.cfg.providerTag <= `SGFL_RST_PTAG;
      state_r.cfg.ringTag <= `SGFL_RST_RTAG;
      {state_r.cfg.shapeFull, state_r.cfg.policeFull} <= `SGFL_RST_SHAPER;
      {state_r.cfg.vlanEnable, state_r.cfg.dropInvalidVid, state_r.cfg.ageCount,
        state_r.cfg.rsvMcLookup, state_r.cfg.tableHashSelect} <= `SGFL_RST_LKP0;
    end else begin
      state_r <= state_nxt;
    end
  end

  // Outputs straight from the state register
  assign s_axi_awready = state_r.awRdy;
  assign s_axi_wready = state_r.wRdy;
  assign s_axi_bvalid = state_r.bValid;
  assign s_axi_bresp = state_r.bResp;
  assign s_axi_arready = state_r.arRdy;
  assign s_axi_rvalid = state_r.rValid;
  assign s_axi_rdata = state_r.rData;
  assign s_axi_rresp = state_r.rResp;
  assign tableIndex = state_r.tableIndex;
  assign keptLen = state_r.keptLen;
  assign frameTagType = state_r.frameTagType;
  assign shapeCost = state_r.shapeCost;
  assign policeCost = state_r.policeCost;
  assign frameDrop = state_r.frameDrop;
  assign toHostPort = state_r.toHostPort;
  assign selfDrop = state_r.selfDrop;
  assign entryAgeCount = state_r.entryAgeCount;
  assign agingTime = state_r.agingTime;
  assign vlanMode = state_r.cfg.vlanEnable;
  assign rsvMcEnable = state_r.cfg.rsvMcLookup;

  ////////////////////////////////////////////////////////////////////////
  // Checks
  trunc_len_a: assert property (@(posedge clk) disable iff (rst)
    frameValid |=> keptLen <= $past(state_r.cfg.maxFrameLen))
    else $error("kept length above maximum");
  jumbo_len_a: assert property (@(posedge clk) disable iff (rst)
    frameValid && frameLen == `SGFL_MAXLEN_JUMBO && state_r.cfg.maxFrameLen == `SGFL_MAXLEN_JUMBO
    |=> keptLen == `SGFL_MAXLEN_JUMBO)
    else $error("jumbo frame not passed");
  untag_type_a: assert property (@(posedge clk) disable iff (rst)
    frameValid && !frameTagged |=> frameTagType == $past(state_r.cfg.providerTag))
    else $error("untagged frame lacks provider tag type");
  shape_cost_a: assert property (@(posedge clk) disable iff (rst)
    frameValid && !state_r.cfg.shapeFull |=> shapeCost == {1'b0, keptLen})
    else $error("shaper charged overhead in data-only mode");
  police_cost_a: assert property (@(posedge clk) disable iff (rst)
    frameValid && state_r.cfg.policeFull |=> policeCost == {1'b0, keptLen} + 15'h0014)
    else $error("policer overhead missing");
  vid_drop_a: assert property (@(posedge clk) disable iff (rst)
    frameValid && unknownVidFwd |=> !frameDrop && !toHostPort)
    else $error("invalid VID drop overrode unknown forwarding");
  age_load_a: assert property (@(posedge clk) disable iff (rst)
    entryUpdate |=> entryAgeCount == $past(state_r.cfg.ageCount))
    else $error("age count not loaded");
  direct_idx_a: assert property (@(posedge clk) disable iff (rst)
    frameValid && state_r.cfg.tableHashSelect inside {2'b00, 2'b11}
    |=> tableIndex == $past(destAddr[9:0]))
    else $error("direct index wrong");
  wr_resp_a: assert property (@(posedge clk) disable iff (rst)
    state_r.awHeld && state_r.wHeld && !state_r.bValid |=> s_axi_bvalid)
    else $error("write response late");
endmodule // sgfl_bank

//--- verification/sgfl_bank_tb.sv
/*
  Self-checking bench for the global frame and lookup configuration bank.
  Assumes the package, the interface and the constants header are compiled first.
*/
`timescale 1ns/100ps
`include "sgfl_consts.svh"
module testbench;
  import sgfl_pkg::*;
  logic clk, rst;
  logic [17:0] s_axi_awaddr, s_axi_araddr;
  logic [31:0] s_axi_wdata, s_axi_rdata;
  logic [3:0] s_axi_wstrb;
  logic [1:0] s_axi_bresp, s_axi_rresp;
  logic s_axi_awvalid, s_axi_awready, s_axi_wvalid, s_axi_wready, s_axi_bvalid, s_axi_bready;
  logic s_axi_arvalid, s_axi_arready, s_axi_rvalid, s_axi_rready;
  logic [47:0] destAddr, srcAddr;
  logic [13:0] frameLen, keptLen;
  logic frameTagged, frameValid, invalidVid, unknownVidFwd, entryUpdate;
  logic [7:0] agePeriod;
  logic [9:0] tableIndex;
  logic [15:0] frameTagType;
  logic [14:0] shapeCost, policeCost;
  logic frameDrop, toHostPort, selfDrop, vlanMode, rsvMcEnable;
  logic [2:0] entryAgeCount;
  logic [10:0] agingTime;
  int n_mismatch, total_checks;

  // Register indices, reset values and writable bits, in three matching tables
  localparam logic [15:0] IDX [8] = '{`SGFL_IDX_STA3, `SGFL_IDX_STA4, `SGFL_IDX_STA5,
    `SGFL_IDX_MAXLEN, `SGFL_IDX_PTAG, `SGFL_IDX_RTAG, `SGFL_IDX_SHAPER, `SGFL_IDX_LKP0};
  localparam logic [31:0] RSTV [8] = '{32'h0000_00FF, 32'h0000_00FF, 32'h0000_00FF,
    32'h0000_07D0, 32'h0000_9100, 32'h0000_892F, 32'h0000_0003, 32'h0000_0061};
  localparam logic [31:0] MASK [8] = '{32'h0000_00FF, 32'h0000_00FF, 32'h0000_00FF,
    32'h0000_FFFF, 32'h0000_FFFF, 32'h0000_FFFF, 32'h0000_0003, 32'h0000_00FF};

`define CHK(got, exp, msg) \
  begin \
    total_checks++; \
    if ((got) !== (exp)) begin \
      n_mismatch++; \
      $display("mismatch at %0t: %s got %h want %h", $time, msg, got, exp); \
    end \
  end

  sgfl_bank i_sgfl_bank (.clk, .rst, .s_axi_awaddr, .s_axi_awvalid, .s_axi_awready,
    .s_axi_wdata, .s_axi_wstrb, .s_axi_wvalid, .s_axi_wready, .s_axi_bresp, .s_axi_bvalid,
    .s_axi_bready, .s_axi_araddr, .s_axi_arvalid, .s_axi_arready, .s_axi_rdata,
    .s_axi_rresp, .s_axi_rvalid, .s_axi_rready, .destAddr, .srcAddr, .frameLen,
    .frameTagged, .frameValid, .invalidVid, .unknownVidFwd, .entryUpdate, .agePeriod,
    .tableIndex, .keptLen, .frameTagType, .shapeCost, .policeCost, .frameDrop, .toHostPort,
    .selfDrop, .entryAgeCount, .agingTime, .vlanMode, .rsvMcEnable);

  // 200 MHz clock
  initial begin
    clk = 1'b0;
    forever #2.5 clk = ~clk;
  end

  ////////////////////////////////////////////////////////////////////////////////
  // Verdict, printed in one place only
  task automatic summarize();
    $display("checks %0d mismatches %0d", total_checks, n_mismatch);
    if (n_mismatch == 0 && total_checks > 0) begin
      $display("No errors found");
    end else begin
      $display("Errors were found");
    end
    $finish;
  endtask

  // A wait that ran out counts as a mismatch and ends the run
  task automatic timed_out(input int t);
    if (t >= 100) begin
      n_mismatch++;
      $display("mismatch at %0t: bus answer never came", $time);
      summarize();
    end
  endtask

  // Write: address and data offered together, each dropped when taken
  task automatic axi_wr(input logic [17:0] a, input logic [31:0] d, output logic [1:0] r);
    int t;
    s_axi_awaddr <= a;
    s_axi_wdata <= d;
    s_axi_wstrb <= 4'hF;
    s_axi_awvalid <= 1'b1;
    s_axi_wvalid <= 1'b1;
    s_axi_bready <= 1'b1;
    for (t = 0; t < 100; t++) begin
      @(posedge clk);
      if (s_axi_awready) s_axi_awvalid <= 1'b0;
      if (s_axi_wready) s_axi_wvalid <= 1'b0;
      if (s_axi_bvalid) break;
    end
    r = s_axi_bresp;
    s_axi_bready <= 1'b0;
    timed_out(t);
    @(posedge clk);
  endtask

  // Read: data and response taken at the edge where rvalid is seen
  task automatic axi_rd(input logic [17:0] a, output logic [31:0] d, output logic [1:0] r);
    int t;
    s_axi_araddr <= a;
    s_axi_arvalid <= 1'b1;
    s_axi_rready <= 1'b1;
    for (t = 0; t < 100; t++) begin
      @(posedge clk);
      if (s_axi_arready) s_axi_arvalid <= 1'b0;
      if (s_axi_rvalid) break;
    end
    d = s_axi_rdata;
    r = s_axi_rresp;
    s_axi_rready <= 1'b0;
    timed_out(t);
    @(posedge clk);
  endtask

  // One frame pulse with an entry update; outputs settle one edge later
  task automatic send_frame(input logic [47:0] da, sa, input logic [13:0] len,
                            input logic tg, iv, uf);
    destAddr <= da;
    srcAddr <= sa;
    frameLen <= len;
    frameTagged <= tg;
    invalidVid <= iv;
    unknownVidFwd <= uf;
    frameValid <= 1'b1;
    entryUpdate <= 1'b1;
    @(posedge clk);
    frameValid <= 1'b0;
    entryUpdate <= 1'b0;
    @(posedge clk);
  endtask

  // Expected table index for each hash choice; CRC feeds back 0x233 from seed 0x3FF
  function automatic logic [9:0] exp_index(input logic [1:0] h, input logic [47:0] a);
    logic [9:0] c;
    c = 10'h3FF;
    if (h == 2'b01) begin
      for (int i = 0; i < 48; i++) c = {c[8:0], 1'b0} ^ ((c[9] ^ a[i]) ? 10'h233 : 10'h000);
      return c;
    end
    if (h == 2'b10) return a[9:0] ^ a[19:10] ^ a[29:20] ^ a[39:30] ^ {2'b00, a[47:40]};
    return a[9:0];
  endfunction

  ////////////////////////////////////////////////////////////////////////////////
  // Main sequence
  initial begin
    logic [31:0] d, v;
    logic [31:0] cfg [8];
    logic [1:0] r;
    logic [47:0] sta, da, sa;
    logic [13:0] len, mx, kl;
    logic tg, iv, uf;
    n_mismatch = 0;
    total_checks = 0;
    rst = 1'b1;
    {s_axi_awaddr, s_axi_araddr, s_axi_wdata, s_axi_wstrb} = '0;
    {s_axi_awvalid, s_axi_wvalid, s_axi_bready, s_axi_arvalid, s_axi_rready} = '0;
    {destAddr, srcAddr, frameLen, frameTagged, frameValid} = '0;
    {invalidVid, unknownVidFwd, entryUpdate, agePeriod} = '0;
    void'($urandom(32'h300b));
    repeat (6) @(posedge clk);
    rst <= 1'b0;
    @(posedge clk);
    // Reset values of every register except the status register, and of the mode outputs
    for (int i = 0; i < 8; i++) begin
      axi_rd({IDX[i], 2'b00}, d, r);
      `CHK(d, RSTV[i], "reset value")
    end
    `CHK({vlanMode, rsvMcEnable}, 2'b00, "mode outputs after reset")
    axi_rd({`SGFL_IDX_STAHI, 2'b00}, d, r);
    `CHK(d, {8'h00, `SGFL_RST_STAHI}, "upper station bytes")
    $display("test reset values done");
    // Random write and read back; bits above each register's width read zero
    for (int k = 0; k < 4; k++) begin
      for (int i = 0; i < 8; i++) begin
        v = (k == 0 && i == 3) ? 32'h0000_2328 : $urandom;
        axi_wr({IDX[i], 2'b00}, v, r);
        `CHK(r, 2'b00, "write response")
        axi_rd({IDX[i], 2'b00}, d, r);
        `CHK(d, v & MASK[i], "read back")
        cfg[i] = v & MASK[i];
      end
    end
    // Unmapped place: write refused, read gives zero with an error
    axi_wr(18'h0_0C04, $urandom, r);
    `CHK(r, 2'b10, "unmapped write response")
    axi_rd(18'h0_0C04, d, r);
    `CHK({r, d}, {2'b10, 32'h0000_0000}, "unmapped read")
    $display("test register access done");
    sta = {`SGFL_RST_STAHI, cfg[0][7:0], cfg[1][7:0], cfg[2][7:0]};
    // Frames under random settings; hash choice walks through all four codes
    for (int k = 0; k < 16; k++) begin
      v = $urandom;
      mx = (k == 0) ? `SGFL_MAXLEN_JUMBO : 14'($urandom_range(9000, 1));
      cfg[3] = {18'h0, mx};
      cfg[6] = {30'h0, v[9:8]};
      cfg[7] = {24'h0, v[7] | k[3], v[6:2], k[1:0]};
      axi_wr({IDX[3], 2'b00}, cfg[3], r);
      axi_wr({IDX[6], 2'b00}, cfg[6], r);
      // The VLAN table sits outside this slice, so the enable may be set at once
      axi_wr({IDX[7], 2'b00}, cfg[7], r);
      agePeriod <= v[31:24];
      len = (k <= 1) ? mx : ((k == 2) ? mx + 14'h0001 : 14'($urandom_range(9000, 1)));
      kl = (len > mx) ? mx : len;
      da = 48'({$urandom, $urandom});
      sa = (k % 4 == 1) ? sta : 48'({$urandom, $urandom});
      tg = v[10];
      iv = v[11] | k[3];
      uf = k[2];
      send_frame(da, sa, len, tg, iv, uf);
      `CHK(keptLen, kl, "kept length")
      `CHK(frameTagType, (tg ? cfg[5][15:0] : cfg[4][15:0]), "tag type")
      `CHK(shapeCost, {1'b0, kl} + (cfg[6][1] ? 15'h0014 : 15'h0000), "shape")
      `CHK(policeCost, {1'b0, kl} + (cfg[6][0] ? 15'h0014 : 15'h0000), "police")
      `CHK(tableIndex, exp_index(k[1:0], da), "table index")
      `CHK(selfDrop, (sa == sta), "own address")
      `CHK({vlanMode, rsvMcEnable}, {cfg[7][7], cfg[7][2]}, "mode outputs")
      if (cfg[7][7] && iv && !uf && sa != sta) `CHK(frameDrop, cfg[7][6], "vid drop")
      if (cfg[7][7] && iv && !uf && sa != sta) `CHK(toHostPort, !cfg[7][6], "to host")
      if (cfg[7][7] && iv && uf && sa != sta) `CHK(frameDrop, 1'b0, "unknown vid wins")
      `CHK(entryAgeCount, cfg[7][5:3], "entry age count")
      `CHK(agingTime, 11'(cfg[7][5:3]) * 11'(v[31:24]), "aging time")
    end
    $display("test frame path done");
    summarize();
  end
endmodule // testbench
